// file: rtl/apmc_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module apmc_cfg
  import apmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output apmc_cfg_t        cfg,
  output logic [2:0]       src_index,
  output logic             src_valid,
  output logic             monitor_clk
);

  // field registers and their next values
  logic [2:0]  overtemp_reg;
  logic [2:0]  overtemp_next;
  logic [2:0]  overcurrent_reg;
  logic [2:0]  overcurrent_next;
  logic [1:0]  freq_reg;
  logic [1:0]  freq_next;
  logic [6:0]  src_reg;
  logic [6:0]  src_next;

  // registered read data and its next value
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // bus requests count only while the clock enable is high
  wire logic        wr_take  = clk_en && reg_wr;
  wire logic        rd_take  = clk_en && reg_rd;

  // address decode; status and unmapped writes fall away
  wire logic        hit_cfg  = (reg_addr == APMC_CFG_OFFSET);
  wire logic        hit_stat = (reg_addr == APMC_STAT_OFFSET);
  wire logic        cfg_wr   = wr_take && hit_cfg;
  wire logic        cfg_rd   = rd_take && hit_cfg;
  wire logic        stat_rd  = rd_take && hit_stat;

  // write data with the reserved bit cleared
  wire logic [15:0] wdata_kept = reg_wdata & APMC_CFG_WMASK;

  // write data split into its fields
  wire logic [2:0]  wr_overtemp    = wdata_kept[APMC_OT_LSB +: 3];
  wire logic [2:0]  wr_overcurrent = wdata_kept[APMC_OC_LSB +: 3];
  wire logic [1:0]  wr_freq        = wdata_kept[APMC_FREQ_LSB +: 2];
  wire logic [6:0]  wr_src         = wdata_kept[APMC_SRC_LSB +: 7];

  // next values: each field holds unless a write hits the register
  assign overtemp_next    = cfg_wr ? wr_overtemp    : overtemp_reg;
  assign overcurrent_next = cfg_wr ? wr_overcurrent : overcurrent_reg;
  assign freq_next        = cfg_wr ? wr_freq        : freq_reg;
  assign src_next         = cfg_wr ? wr_src         : src_reg;

  // over-temperature enables, all off after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overtemp_reg <= APMC_CFG_RESET[APMC_OT_LSB +: 3];
    end else if (clk_en) begin
      overtemp_reg <= overtemp_next;
    end
  end

  // overcurrent enables, inputs 2 and 4 on after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overcurrent_reg <= APMC_CFG_RESET[APMC_OC_LSB +: 3];
    end else if (clk_en) begin
      overcurrent_reg <= overcurrent_next;
    end
  end

  // monitor frequency code, slowest after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      freq_reg <= APMC_CFG_RESET[APMC_FREQ_LSB +: 2];
    end else if (clk_en) begin
      freq_reg <= freq_next;
    end
  end

  // monitor source selects, none after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      src_reg <= APMC_CFG_RESET[APMC_SRC_LSB +: 7];
    end else if (clk_en) begin
      src_reg <= src_next;
    end
  end

  // per-input protection enables
  wire logic        input1_overtemp_enable    = overtemp_reg[2];    // bit 15
  wire logic        input3_overtemp_enable    = overtemp_reg[1];    // bit 14
  wire logic        input5_overtemp_enable    = overtemp_reg[0];    // bit 13
  wire logic        input2_overcurrent_enable = overcurrent_reg[2]; // bit 12
  wire logic        input4_overcurrent_enable = overcurrent_reg[1]; // bit 11
  wire logic        input6_overcurrent_enable = overcurrent_reg[0]; // bit 10

  // per-source monitor selects
  wire logic        monitor_src_input1   = src_reg[0]; // bit 0
  wire logic        monitor_src_input3   = src_reg[1]; // bit 1
  wire logic        monitor_src_input5   = src_reg[2]; // bit 2
  wire logic        monitor_src_input2   = src_reg[3]; // bit 3
  wire logic        monitor_src_input4   = src_reg[4]; // bit 4
  wire logic        monitor_src_input6   = src_reg[5]; // bit 5
  wire logic        monitor_src_die_temp = src_reg[6]; // bit 6

  // select vector in register order, bit 0 first
  wire logic [6:0]  src = {monitor_src_die_temp, monitor_src_input6, monitor_src_input4, monitor_src_input2,
                           monitor_src_input5, monitor_src_input3, monitor_src_input1};

  // field outputs
  assign cfg = '{overtemp_en:             {input1_overtemp_enable, input3_overtemp_enable,
                                           input5_overtemp_enable},
                 overcurrent_en:          {input2_overcurrent_enable, input4_overcurrent_enable,
                                           input6_overcurrent_enable},
                 monitor_output_freq_sel: freq_reg,
                 monitor_src:             src};

  // lowest set select isolated; it wins if several are set
  wire logic [6:0]  lowest_sel   = src & (~src + 7'h01);
  wire logic [2:0]  lowest_index = {lowest_sel[4] | lowest_sel[5] | lowest_sel[6],
                                    lowest_sel[2] | lowest_sel[3] | lowest_sel[6],
                                    lowest_sel[1] | lowest_sel[3] | lowest_sel[5]};

  // source present flag and index, 7 when nothing is selected
  assign src_valid = |src;
  assign src_index = src_valid ? lowest_index : 3'h7;

  // more than one select bit set
  wire logic [6:0]  src_low  = src & (src - 7'h01);
  wire logic        multi    = |src_low;

  // register as software reads it; reserved bit always zero
  wire logic [15:0] cfg_view    = {overtemp_reg, overcurrent_reg, freq_reg, 1'b0, src_reg};

  // status word: multiple-select flag above the source index
  wire logic [15:0] status_view = (16'(multi) << APMC_STAT_ERR_BIT) | {13'h0000, src_index};

  // read mux; unmapped reads and idle cycles return zero
  assign rdata_next = cfg_rd  ? cfg_view :
                      stat_rd ? status_view :
                      16'h0000;

  // read data stands for the one cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 16'h0000;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // frequency code decode into a half period in clock cycles
  wire logic        freq_is0 = (freq_reg == 2'h0);
  wire logic        freq_is1 = (freq_reg == 2'h1);
  wire logic        freq_is2 = (freq_reg == 2'h2);
  wire logic [10:0] half     = freq_is0 ? APMC_HALF0 :
                               freq_is1 ? APMC_HALF1 :
                               freq_is2 ? APMC_HALF2 :
                               APMC_HALF3;

  // monitor timebase, idle when no source selected
  apmc_clk_div u_div (
    .clock       (clock),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .run         (src_valid),
    .half_period (half),
    .wave        (monitor_clk)
  );

endmodule
`default_nettype wire

// file: rtl/apmc_pkg.sv
`default_nettype none
package apmc_pkg;

  localparam logic [3:0]  APMC_CFG_OFFSET   = 4'h0;
  localparam logic [3:0]  APMC_STAT_OFFSET  = 4'h1;
  localparam logic [15:0] APMC_CFG_RESET    = 16'h1800;
  localparam logic [15:0] APMC_CFG_WMASK    = 16'hff7f;
  localparam int          APMC_OT_LSB       = 13;
  localparam int          APMC_OC_LSB       = 10;
  localparam int          APMC_FREQ_LSB     = 8;
  localparam int          APMC_SRC_LSB      = 0;
  localparam int          APMC_STAT_ERR_BIT = 8;

  // monitor output frequencies in hertz (tenths of khz scaled)
  localparam int          APMC_CLK_HZ       = 25000000;
  localparam int          APMC_F0_HZ        = 13900;
  localparam int          APMC_F1_HZ        = 27800;
  localparam int          APMC_F2_HZ        = 55700;
  localparam int          APMC_F3_HZ        = 111400;
  // half periods in cycles, rounded down
  localparam logic [10:0] APMC_HALF0 = 11'(APMC_CLK_HZ / (2 * APMC_F0_HZ));
  localparam logic [10:0] APMC_HALF1 = 11'(APMC_CLK_HZ / (2 * APMC_F1_HZ));
  localparam logic [10:0] APMC_HALF2 = 11'(APMC_CLK_HZ / (2 * APMC_F2_HZ));
  localparam logic [10:0] APMC_HALF3 = 11'(APMC_CLK_HZ / (2 * APMC_F3_HZ));

  typedef struct packed {
    logic [2:0] overtemp_en;   // inputs 1,3,5
    logic [2:0] overcurrent_en; // inputs 2,4,6
    logic [1:0] monitor_output_freq_sel;
    logic [6:0] monitor_src;   // die temp,6,4,2,5,3,1
  } apmc_cfg_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } apmc_bus_t;

endpackage
`default_nettype wire

// file: rtl/apmc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// square wave generator with a selectable half period
module apmc_clk_div
  import apmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        run,
  input  wire logic [10:0] half_period,
  output logic             wave
);

  logic [10:0] count_reg;
  logic        wave_reg;
  wire  logic  wrap = (count_reg >= half_period - 11'h001);

  // count and toggle; idle low while not running
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 11'h000;
      wave_reg  <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count_reg <= 11'h000;
        wave_reg  <= 1'b0;
      end else if (wrap) begin
        count_reg <= 11'h000;
        wave_reg  <= ~wave_reg;
      end else begin
        count_reg <= count_reg + 11'h001;
      end
    end
  end

  assign wave = wave_reg;

endmodule
`default_nettype wire

// file: tb/apmc_cfg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module apmc_cfg_assertions
  import apmc_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire apmc_cfg_t   cfg,
  input wire logic        src_valid,
  input wire logic        monitor_clk
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // a write taken by the config register
  sequence s_wr; clk_en && reg_wr && reg_addr == APMC_CFG_OFFSET; endsequence
  // a read taken by the config register
  sequence s_rd_cfg; clk_en && reg_rd && reg_addr == APMC_CFG_OFFSET; endsequence
  // no source over two clocked cycles
  sequence s_no_src; (!src_valid && clk_en) ##1 !src_valid; endsequence
  a_reset_vals: assert property ($rose(reset_n) |-> cfg == 15'h0c00) else $error("bad reset");
  a_ot_write: assert property (s_wr |=> cfg.overtemp_en == $past(reg_wdata[15:13])) else $error("ot");
  a_oc_write: assert property (s_wr |=> cfg.overcurrent_en == $past(reg_wdata[12:10])) else $error("oc");
  a_freq_write: assert property (
    s_wr |=> cfg.monitor_output_freq_sel == $past(reg_wdata[9:8])) else $error("freq");
  a_src_write: assert property (s_wr |=> cfg.monitor_src[5:0] == $past(reg_wdata[5:0])) else $error("src");
  a_die_src: assert property (s_wr |=> cfg.monitor_src[6] == $past(reg_wdata[6])) else $error("die");
  a_idle_low: assert property (s_no_src |-> !monitor_clk) else $error("idle");
  a_rsvd_read: assert property (clk_en && reg_rd |=> !reg_rdata[7]) else $error("rsvd");
  a_cfg_readback: assert property (
    s_rd_cfg |=> reg_rdata == {$past(cfg[14:7]), 1'b0, $past(cfg[6:0])}) else $error("config read data");
  a_freeze_hold: assert property (
    !clk_en |=> $stable(cfg) && $stable(monitor_clk) && $stable(reg_rdata)) else $error("state moved while frozen");
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import apmc_pkg::*;;
  logic        clock = 1'h0, reset_n = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, src_valid, monitor_clk;
  logic [2:0]  src_index;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, w, lf = 16'h0041;
  apmc_cfg_t   cfg;
  logic        wave_seen;
  int          miscompares = 0, checks_done = 0, n;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
  apmc_cfg apmc_cfg_i (
    .clock       (clock),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .cfg         (cfg),
    .src_index   (src_index),
    .src_valid   (src_valid),
    .monitor_clk (monitor_clk)
  );
  // free running clock
  initial forever #20 clock = ~clock;
  function automatic logic [15:0] step(logic [15:0] s); return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]}; endfunction
  function automatic int halfp(int c); int f[4] = '{13900, 27800, 55700, 111400}; return 12500000 / f[c]; endfunction
  // status expected: lowest set select as index, flag when several are set
  function automatic logic [15:0] stat_exp(logic [6:0] s);
    logic [2:0] idx;
    int         ones;
    idx = 3'h7;
    ones = 0;
    for (int k = 6; k >= 0; k--) if (s[k]) begin idx = 3'(k); ones++; end
    return {7'h00, ones > 1, 5'h00, idx};
  endfunction
  // one-cycle bus strobes
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog
  initial begin
    #1600000;
    miscompares++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'h1;
    #1 `CHK(monitor_clk, 1'h0)
    `CHK(src_valid, 1'h0)
    rd(APMC_CFG_OFFSET, APMC_CFG_RESET);
    for (int i = 0; i < 40; i++) begin
      lf = step(lf);
      w = {lf[15:7], 7'(16'h1 << lf[2:0])};
      wr(4'h0, w);
      `CHK(cfg, {w[15:8], w[6:0]})
      `CHK(src_valid, |w[6:0])
      rd(4'h0, w & 16'hff7f);
      rd(APMC_STAT_OFFSET, stat_exp(w[6:0]));
    end
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    rd(4'h0, w & 16'hff7f);
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, {6'h0, 2'(c), 8'h01});
      @(posedge monitor_clk);
      n = 0;
      do begin @(posedge clock); #1; n++; end while (monitor_clk === 1'h1);
      `CHK(n, halfp(c))
    end
    // clock enable low: a write is ignored and the wave holds
    @(posedge clock);
    clk_en <= 1'h0;
    #1 wave_seen = monitor_clk;
    wr(APMC_CFG_OFFSET, 16'h0000);
    repeat (3) @(posedge clock);
    #1 `CHK(cfg, {8'h03, 7'h01})
    `CHK(monitor_clk, wave_seen)
    @(posedge clock);
    clk_en <= 1'h1;
    // reset in mid-run returns every field to its reset value
    @(posedge clock);
    reset_n <= 1'h0;
    #1 `CHK(monitor_clk, 1'h0)
    `CHK(cfg, 15'h0c00)
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    rd(APMC_CFG_OFFSET, APMC_CFG_RESET);
    final_report;
  end
endmodule
bind apmc_cfg apmc_cfg_assertions apmc_cfg_assertions_i (
  .clock       (clock),
  .reset_n     (reset_n),
  .clk_en      (clk_en),
  .reg_addr    (reg_addr),
  .reg_wdata   (reg_wdata),
  .reg_wr      (reg_wr),
  .reg_rd      (reg_rd),
  .reg_rdata   (reg_rdata),
  .cfg         (cfg),
  .src_valid   (src_valid),
  .monitor_clk (monitor_clk)
);
`default_nettype wire
